// ===== dv/aic_sensor_model.sv
/* Analog side: sensors, calibration and reference detector.
   Driven by bench tasks. */
`timescale 1ns/1ps
`default_nettype none
module aic_sensor_model #(
    parameter int RES_W = 16
) (
    input  wire logic             clk_i,   // Core clock
    output logic      [1:0]       valid_o, // Result strobes
    output logic      [RES_W+1:0] raw_o,   // Raw value
    output logic      [1:0]       start_o, // Cal start
    output logic      [1:0]       done_o,  // Cal end
    output logic      [1:0]       gain_o,  // Gain cal select
    output logic      [RES_W-1:0] coef_o,  // New coefficient
    output logic                  fault_o  // Reference missing
);
    initial {valid_o, start_o, done_o, gain_o, fault_o, raw_o, coef_o} = '0;
    // Raw inverts after the strobe
    task conv(input int ch, input logic [RES_W+1:0] v);
        @(posedge clk_i);
        raw_o <= v;
        valid_o[ch] <= 1'b1;
        @(posedge clk_i);
        valid_o <= 2'h0;
        raw_o <= ~v;
    endtask
    task set_ref(input logic f);
        @(posedge clk_i);
        fault_o <= f;
    endtask
    // drop: reference lost in window
    task cal(input int ch, input logic g, input logic [RES_W-1:0] c, input logic drop);
        @(posedge clk_i);
        start_o[ch] <= 1'b1;
        @(posedge clk_i);
        start_o <= 2'h0;
        fault_o <= drop;
        repeat (4) @(posedge clk_i);
        done_o[ch] <= 1'b1;
        gain_o[ch] <= g;
        coef_o <= c;
        @(posedge clk_i);
        done_o <= 2'h0;
        coef_o <= ~c;
        fault_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== dv/aic_top_chk.sv
/* Assertions on aic_top ports, bound in.
   Assumes one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module aic_top_chk #(
    parameter int RES_W = 16
) (
    input wire logic             clk_i,          // Clock
    input wire logic             rst_i,          // Reset
    input wire logic             wb_cyc_i,       // Cycle
    input wire logic             wb_stb_i,       // Strobe
    input wire logic             wb_ack_o,       // Ack
    input wire logic [1:0]       conv_valid_i,   // Result strobes
    input wire logic [RES_W+1:0] pri_raw_i,      // Raw value
    input wire logic [1:0]       cal_start_i,    // Cal start
    input wire logic [1:0]       cal_done_i,     // Cal end
    input wire logic             ref_fault_i,    // Detector
    input wire logic             pri_unipolar_o, // Polarity
    input wire logic [1:0]       exc_out_one_o,  // Pin one units
    input wire logic [1:0]       exc_out_two_o,  // Pin two units
    input wire logic             ref_missing_o,  // Missing flag
    input wire logic [RES_W-1:0] pri_data_o,     // Result
    input wire logic [RES_W-1:0] pri_gn_coef_o   // Gain coef
);
    logic act0;
    logic next_act0;
    // Primary cal window
    always_comb next_act0 = cal_start_i[0] | (act0 & ~cal_done_i[0]);
    always_ff @(posedge clk_i) act0 <= rst_i ? 1'b0 : next_act0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    chk_ref_tracks: assert property (1'b1 |=> ref_missing_o == $past(ref_fault_i))
        else $error("flag lag");
    chk_force_ones: assert property (conv_valid_i[0] && !act0 && ref_missing_o
        |=> pri_data_o == '1) else $error("not ones");
    chk_unipolar_code: assert property (conv_valid_i[0] && !act0 && !ref_missing_o
        && pri_unipolar_o && !pri_raw_i[RES_W+1] && !pri_raw_i[RES_W]
        |=> pri_data_o == $past(pri_raw_i[RES_W-1:0])) else $error("bad straight code");
    chk_bipolar_code: assert property (conv_valid_i[0] && !act0 && !ref_missing_o
        && !pri_unipolar_o && pri_raw_i[RES_W+1] == pri_raw_i[RES_W]
        |=> pri_data_o == {~$past(pri_raw_i[RES_W]), $past(pri_raw_i[RES_W-1:1])})
        else $error("bad offset code");
    chk_exc_total: assert property (exc_out_one_o != 2'h3 && exc_out_two_o != 2'h3
        && ({1'b0, exc_out_one_o} + {1'b0, exc_out_two_o}) inside {3'h0, 3'h2})
        else $error("bad exc");
    chk_coef_hold: assert property (cal_done_i[0] && ref_missing_o
        |=> $stable(pri_gn_coef_o)) else $error("coef moved");
endmodule
bind aic_top aic_top_chk #(.RES_W(RES_W)) u_chk (.*);
`default_nettype wire

// ===== dv/test_adc_input_ref_control.sv
/* Bench for aic_top and its bus.
   Assumes the sensor model as analog side. */
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_ref_control
    import aic_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, pri_unipolar_o, pri_ext_ref_o, pri_int_ref_o, aux_unipolar_o, irq_o;
    logic        aux_ext_ref_o, aux_int_ref_o, burnout_enable_o, ref_missing_o, ref_fault_i;
    logic [1:0]  conv_valid_i, cal_start_i, cal_done_i, cal_gain_i, exc_out_one_o, exc_out_two_o;
    logic [2:0]  pri_range_o;
    logic [17:0] pri_raw_i, aux_raw_i;
    logic [15:0] pri_cal_coef_i, aux_cal_coef_i, pri_data_o, aux_data_o, pri_off_coef_o;
    logic [15:0] pri_gn_coef_o, aux_off_coef_o, aux_gn_coef_o;
    int          n_mismatch = 0, check_count = 0, cycles = 0;
    aic_top u_dut (.*);
    aic_sensor_model u_sen (.clk_i(clk_i), .valid_o(conv_valid_i), .raw_o(pri_raw_i),
        .start_o(cal_start_i), .done_o(cal_done_i), .gain_o(cal_gain_i),
        .coef_o(pri_cal_coef_i), .fault_o(ref_fault_i));
    assign aux_raw_i = pri_raw_i;
    assign aux_cal_coef_i = pri_cal_coef_i;
    always #12.5 clk_i = ~clk_i;
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Classic cycle; write visible on return
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        check(wb_ack_o, 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        #1;
    endtask
    task t_ctrl;
        for (int r = 0; r < 8; r++) begin
            wb(1'b1, OFS_PRI_CTRL, 32'(r * 4 + 3));
            check({pri_range_o, pri_ext_ref_o, pri_int_ref_o, pri_unipolar_o}, 32'(r * 8 + 5));
        end
        wb(1'b0, OFS_PRI_CTRL, 32'h0);
        check(rd, 32'h1F);
        wb(1'b1, OFS_AUX_CTRL, 32'h1);
        check({aux_unipolar_o, aux_ext_ref_o, aux_int_ref_o, pri_unipolar_o}, 32'hB);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, 32'h0);
        check(rd, 32'h0);
    endtask
    task t_cur;
        logic [3:0] pins [4] = '{4'h0, 4'h5, 4'h8, 4'h2};
        for (int m = 0; m < 5; m++) begin
            wb(1'b1, OFS_CUR_CTRL, m < 4 ? 32'(m * 2 + 1) : 32'h0);
            check({burnout_enable_o, exc_out_one_o, exc_out_two_o}, m < 4 ? {1'b1, pins[m]} : 0);
        end
    endtask
    task t_code;
        logic [17:0] raw [4] = '{18'h30000, 18'h00000, 18'h08000, 18'h10000};
        logic [15:0] eu [4] = '{16'h0000, 16'h0000, 16'h8000, 16'hFFFF};
        logic [15:0] eb [4] = '{16'h0000, 16'h8000, 16'hC000, 16'hFFFF};
        for (int u = 0; u < 2; u++) begin
            wb(1'b1, OFS_PRI_CTRL, 32'(2 + u));
            wb(1'b1, OFS_AUX_CTRL, 32'(3 - u));
            for (int i = 0; i < 4; i++) begin
                u_sen.conv(0, raw[i]);
                u_sen.conv(1, raw[i]);
                #1;
                check(pri_data_o, u ? eu[i] : eb[i]);
                check(aux_data_o, u ? eb[i] : eu[i]);
            end
        end
    endtask
    task t_loss;
        for (int f = 1; f >= 0; f--) begin
            u_sen.set_ref(f[0]);
            @(posedge clk_i);
            #1;
            check(ref_missing_o, f[0]);
            u_sen.conv(0, 18'h08000);
            wb(1'b0, OFS_DATA[0], 32'h0);
            check(rd, f ? 32'hFFFF : 32'h8000);
            wb(1'b0, OFS_LIVE, 32'h0);
            check(rd[LV_REFMISS], f[0]);
        end
    endtask
    task t_cal;
        wb(1'b1, OFS_MASK, 32'h18);
        wb(1'b1, OFS_STATUS, 32'h1F);
        u_sen.cal(0, 1'b1, 16'h1234, 1'b0);
        u_sen.cal(0, 1'b0, 16'h0042, 1'b0);
        #1;
        check({pri_gn_coef_o, pri_off_coef_o}, 32'h1234_0042);
        check(irq_o, 1'b0);
        for (int c = 0; c < 2; c++) begin
            u_sen.cal(c, 1'b1, 16'hBEEF, 1'b1);
            #1;
            check(irq_o, 1'b1);
            wb(1'b0, OFS_STATUS, 32'h0);
            check({rd[ST_PRIMARY_CAL_ERROR + c], rd[ST_DONE0 + c]}, 32'h3);
            wb(1'b1, OFS_STATUS, 32'(1 << (ST_PRIMARY_CAL_ERROR + c)));
            check(irq_o, 1'b0);
        end
        check({pri_gn_coef_o, aux_gn_coef_o}, 32'h1234_8000);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check({pri_int_ref_o, aux_int_ref_o, burnout_enable_o, irq_o}, 32'hC);
        check({pri_gn_coef_o, pri_off_coef_o}, 32'h8000_0000);
        t_ctrl;
        t_cur;
        t_code;
        t_loss;
        t_cal;
        finish_test;
    end
endmodule
`default_nettype wire

// ===== rtl/aic_code_fmt.sv
/*
 * Straight or offset binary coding of a signed value, saturating.
 * Assumes raw_i is two's complement, +/-2**W being full scale.
 */
`timescale 1ns/1ps
`default_nettype none
module aic_code_fmt #(
    parameter int W = 16
) (
    input  wire logic signed [W+1:0] raw_i,     // Signed filter value
    input  wire logic                unipolar_i, // 1: straight binary
    output logic             [W-1:0] code_o     // Formatted code
);
    localparam logic signed [W+2:0] HALF = (W+3)'(2**W);
    localparam logic signed [W+2:0] TOP  = (W+3)'(2**W - 1);

    logic signed [W+2:0] ext;
    logic signed [W+2:0] bip;
    logic signed [W+2:0] pick;

    always_comb begin
        ext  = {raw_i[W+1], raw_i};
        bip  = (ext + HALF) >>> 1;               // R2
        pick = unipolar_i ? ext : bip;           // R1
        if (pick < 0) begin
            code_o = '0;
        end else if (pick > TOP) begin
            code_o = '1;
        end else begin
            code_o = pick[W-1:0];
        end
    end
endmodule
`default_nettype wire

// ===== rtl/aic_irq.sv
/*
 * Sticky W1C status, mask and level interrupt; set beats clear.
 * Assumes single-cycle strobes synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module aic_irq #(
    parameter int N = 5
) (
    input  wire logic         clk_i,     // Core clock
    input  wire logic         rst_i,     // Sync reset, active high
    input  wire logic [N-1:0] event_i,   // Event pulses
    input  wire logic [N-1:0] clr_i,     // Write-one-to-clear strobes
    input  wire logic         mask_we_i, // Mask write strobe
    input  wire logic [N-1:0] mask_d_i,  // Mask write data
    output logic      [N-1:0] status_o,  // Sticky status
    output logic      [N-1:0] mask_o,    // Mask
    output logic              irq_o      // Level interrupt
);
    logic [N-1:0] next_status;
    logic [N-1:0] next_mask;

    for (genvar i = 0; i < N; i++) begin : g_bit
        always_comb begin
            next_status[i] = event_i[i] | (status_o[i] & ~clr_i[i]);
        end
    end

    always_comb begin
        next_mask = mask_we_i ? mask_d_i : mask_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= '0;
            mask_o   <= N'(5'h00);
            irq_o    <= 1'b0;
        end else begin
            status_o <= next_status;
            mask_o   <= next_mask;
            irq_o    <= |(next_status & next_mask);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/aic_top.sv
/*
 * Converter polarity, range, reference and current source control with
 * reference-loss guarding, behind a Wishbone slave.
 * Assumes synchronous inputs; conv_valid_i and cal_*_i pulse one cycle.
 */
// The register offsets and the Wishbone register port are this design's own decisions.
// Functional notes
// R1 - Unipolar gives straight binary codes
// R2 - Bipolar gives offset binary codes
// R3 - Polarity changes coding only, not conditioning
// R4 - Each converter has its own unipolar bit
// R5 - Primary gain stage has eight ranges
// R6 - Auxiliary converter has one fixed range
// R7 - One bit switches both burnout currents
// R8 - Software reads full-scale open, zero shorted
// R9 - Excitation routed split or combined
// R10 - Set select bit uses external reference
// R11 - Clear select bit uses internal bandgap
// R12 - Software should prefer the external reference
// R13 - Reference loss sets missing flag
// R14 - Missing reference forces results all ones
// R15 - Loss in calibration blocks coefficients, flags
// R16 - Software checks flags on all-ones results
// R17 - Software polls done flags for calibration
// R18 - Missing flag follows detector, clears afterwards
`timescale 1ns/1ps
`default_nettype none
module aic_top
    import aic_pkg::*;
#(
    parameter int RES_W = 16
) (
    input  wire logic               clk_i,            // Core clock, 40 MHz
    input  wire logic               rst_i,            // Sync reset, active high
    input  wire logic               wb_cyc_i,         // Wishbone cycle
    input  wire logic               wb_stb_i,         // Wishbone strobe
    input  wire logic               wb_we_i,          // Wishbone write enable
    input  wire logic [ADR_W-1:0]   wb_adr_i,         // Byte address
    input  wire logic [3:0]         wb_sel_i,         // Byte selects
    input  wire logic [31:0]        wb_dat_i,         // Write data
    output logic      [31:0]        wb_dat_o,         // Read data
    output logic                    wb_ack_o,         // Acknowledge
    input  wire logic [1:0]         conv_valid_i,     // Result strobes
    input  wire logic [RES_W+1:0]   pri_raw_i,        // Primary filter value
    input  wire logic [RES_W+1:0]   aux_raw_i,        // Auxiliary filter value
    input  wire logic [1:0]         cal_start_i,      // Calibration start
    input  wire logic [1:0]         cal_done_i,       // Calibration end
    input  wire logic [RES_W-1:0]   pri_cal_coef_i,   // Primary new coefficient
    input  wire logic [RES_W-1:0]   aux_cal_coef_i,   // Auxiliary new coefficient
    input  wire logic [1:0]         cal_gain_i,       // 1: gain, 0: offset
    input  wire logic               ref_fault_i,      // Reference detector
    output logic                    pri_unipolar_o,   // Primary unipolar
    output logic [RANGE_W-1:0]      pri_range_o,      // Primary gain_stage range
    output logic                    pri_ext_ref_o,    // Primary external ref
    output logic                    pri_int_ref_o,    // Primary bandgap ref
    output logic                    aux_unipolar_o,   // Auxiliary unipolar
    output logic                    aux_ext_ref_o,    // Auxiliary external ref
    output logic                    aux_int_ref_o,    // Auxiliary bandgap ref
    output logic                    burnout_enable_o, // Both burnout currents
    output logic [1:0]              exc_out_one_o,    // 200 uA units, pin one
    output logic [1:0]              exc_out_two_o,    // 200 uA units, pin two
    output logic                    ref_missing_o,    // reference_missing_flag
    output logic [RES_W-1:0]        pri_data_o,       // Primary result
    output logic [RES_W-1:0]        aux_data_o,       // Auxiliary result
    output logic [RES_W-1:0]        pri_off_coef_o,   // Primary offset coef
    output logic [RES_W-1:0]        pri_gn_coef_o,    // Primary gain coef
    output logic [RES_W-1:0]        aux_off_coef_o,   // Auxiliary offset coef
    output logic [RES_W-1:0]        aux_gn_coef_o,    // Auxiliary gain coef
    output logic                    irq_o             // Level interrupt
);
    if (RES_W < 8 || RES_W > 16) begin : g_chk
        $error("RES_W must lie in 8..16");
    end

    function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
        return a[ADR_W-1:2] == ofs[7:2];
    endfunction

    // Byte-lane write merge
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic                  req;
    logic                  wr;
    logic                  next_ack;
    logic [31:0]           next_rdata;
    logic [PRI_CTRL_W-1:0] pri_ctrl;
    logic [PRI_CTRL_W-1:0] next_pri_ctrl;
    logic [AUX_CTRL_W-1:0] aux_ctrl;
    logic [AUX_CTRL_W-1:0] next_aux_ctrl;
    logic [CUR_CTRL_W-1:0] cur_ctrl;
    logic [CUR_CTRL_W-1:0] next_cur_ctrl;
    logic                  ref_missing;
    logic                  ref_missing_d;
    logic [ST_W-1:0]       events;
    logic [ST_W-1:0]       clr;
    logic [ST_W-1:0]       status;
    logic [ST_W-1:0]       mask;
    logic [1:0]            cal_active;
    logic [1:0]            uni;
    logic [RES_W+1:0]      raw     [2];
    logic [RES_W-1:0]      cal_coef [2];
    logic [RES_W-1:0]      code    [2];
    logic [RES_W-1:0]      data    [2];
    logic [RES_W-1:0]      coef_off [2];
    logic [RES_W-1:0]      coef_gn  [2];

    // Bus: ack one cycle after the request; writes land at the ack edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr  = req & wb_we_i & wb_ack_o;

    always_comb begin
        next_ack = req & ~wb_ack_o;
        next_pri_ctrl = pri_ctrl;
        next_aux_ctrl = aux_ctrl;
        next_cur_ctrl = cur_ctrl;
        if (wr && hit(wb_adr_i, OFS_PRI_CTRL)) begin
            next_pri_ctrl = PRI_CTRL_W'(wmerge(32'(pri_ctrl), wb_dat_i, wb_sel_i)); // R4 R5
        end
        if (wr && hit(wb_adr_i, OFS_AUX_CTRL)) begin
            next_aux_ctrl = AUX_CTRL_W'(wmerge(32'(aux_ctrl), wb_dat_i, wb_sel_i)); // R4 R6
        end
        if (wr && hit(wb_adr_i, OFS_CUR_CTRL)) begin
            next_cur_ctrl = CUR_CTRL_W'(wmerge(32'(cur_ctrl), wb_dat_i, wb_sel_i)); // R7 R9
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (hit(wb_adr_i, OFS_PRI_CTRL)) begin
            next_rdata = 32'(pri_ctrl);
        end else if (hit(wb_adr_i, OFS_AUX_CTRL)) begin
            next_rdata = 32'(aux_ctrl);
        end else if (hit(wb_adr_i, OFS_CUR_CTRL)) begin
            next_rdata = 32'(cur_ctrl);
        end else if (hit(wb_adr_i, OFS_STATUS)) begin
            next_rdata = 32'(status);
        end else if (hit(wb_adr_i, OFS_MASK)) begin
            next_rdata = 32'(mask);
        end else if (hit(wb_adr_i, OFS_LIVE)) begin
            next_rdata = 32'({cal_active, ref_missing});
        end else if (hit(wb_adr_i, OFS_DATA[0])) begin
            next_rdata = 32'(data[0]);
        end else if (hit(wb_adr_i, OFS_DATA[1])) begin
            next_rdata = 32'(data[1]);
        end else if (hit(wb_adr_i, OFS_COEF_OFF[0])) begin
            next_rdata = 32'(coef_off[0]);
        end else if (hit(wb_adr_i, OFS_COEF_GN[0])) begin
            next_rdata = 32'(coef_gn[0]);
        end else if (hit(wb_adr_i, OFS_COEF_OFF[1])) begin
            next_rdata = 32'(coef_off[1]);
        end else if (hit(wb_adr_i, OFS_COEF_GN[1])) begin
            next_rdata = 32'(coef_gn[1]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h00000000;
            pri_ctrl      <= PRI_CTRL_RST;
            aux_ctrl      <= AUX_CTRL_RST;
            cur_ctrl      <= CUR_CTRL_RST;
            ref_missing   <= 1'b0;
            ref_missing_d <= 1'b0;
        end else begin
            wb_ack_o      <= next_ack;
            wb_dat_o      <= next_ack ? next_rdata : 32'h00000000;
            pri_ctrl      <= next_pri_ctrl;
            aux_ctrl      <= next_aux_ctrl;
            cur_ctrl      <= next_cur_ctrl;
            ref_missing   <= ref_fault_i;                               // R13 R18
            ref_missing_d <= ref_missing;
        end
    end

    // Analog front-end controls
    always_comb begin
        pri_unipolar_o   = pri_ctrl[CTL_UNI_BIT];                       // R3 R4
        pri_range_o      = pri_ctrl[CTL_RANGE_LSB +: RANGE_W];          // R5
        pri_ext_ref_o    = pri_ctrl[CTL_XREF_BIT];                      // R10
        pri_int_ref_o    = ~pri_ctrl[CTL_XREF_BIT];                     // R11
        aux_unipolar_o   = aux_ctrl[CTL_UNI_BIT];                       // R4
        aux_ext_ref_o    = aux_ctrl[CTL_XREF_BIT];                      // R6 R10
        aux_int_ref_o    = ~aux_ctrl[CTL_XREF_BIT];                     // R11
        burnout_enable_o = cur_ctrl[CUR_BO_BIT];                        // R7
        ref_missing_o    = ref_missing;
        case (aic_exc_t'(cur_ctrl[CUR_EXC_LSB +: EXC_W]))               // R9
            EXC_SPLIT: begin
                exc_out_one_o = 2'h1;
                exc_out_two_o = 2'h1;
            end
            EXC_BOTH_ONE: begin
                exc_out_one_o = 2'h2;
                exc_out_two_o = 2'h0;
            end
            EXC_BOTH_TWO: begin
                exc_out_one_o = 2'h0;
                exc_out_two_o = 2'h2;
            end
            default: begin
                exc_out_one_o = 2'h0;
                exc_out_two_o = 2'h0;
            end
        endcase
    end

    assign uni[0]      = pri_ctrl[CTL_UNI_BIT];
    assign uni[1]      = aux_ctrl[CTL_UNI_BIT];
    assign raw[0]      = pri_raw_i;
    assign raw[1]      = aux_raw_i;
    assign cal_coef[0] = pri_cal_coef_i;
    assign cal_coef[1] = aux_cal_coef_i;

    // Per-converter result and calibration path
    for (genvar c = 0; c < 2; c++) begin : g_conv
        logic             lost;
        logic             next_lost;
        logic             next_active;
        logic [RES_W-1:0] next_data;
        logic [RES_W-1:0] next_off;
        logic [RES_W-1:0] next_gn;
        logic             store;

        aic_code_fmt #(
            .W          (RES_W)
        ) u_fmt (
            .raw_i      ($signed(raw[c])),
            .unipolar_i (uni[c]),
            .code_o     (code[c])
        );

        always_comb begin
            next_data   = data[c];
            next_off    = coef_off[c];
            next_gn     = coef_gn[c];
            next_active = cal_active[c];
            next_lost   = lost;
            if (conv_valid_i[c] && !cal_active[c]) begin
                next_data = ref_missing ? '1 : code[c];                 // R14
            end
            if (cal_start_i[c]) begin
                next_active = 1'b1;
                next_lost   = 1'b0;
            end else if (cal_active[c] && ref_missing) begin
                next_lost   = 1'b1;                                     // R15
            end
            store = cal_done_i[c] && cal_active[c] && !lost && !ref_missing; // R15
            if (cal_done_i[c]) begin
                next_active = 1'b0;
            end
            if (wr && hit(wb_adr_i, OFS_COEF_OFF[c])) begin
                next_off = RES_W'(wmerge(32'(coef_off[c]), wb_dat_i, wb_sel_i));
            end else if (store && !cal_gain_i[c]) begin
                next_off = cal_coef[c];
            end
            if (wr && hit(wb_adr_i, OFS_COEF_GN[c])) begin
                next_gn = RES_W'(wmerge(32'(coef_gn[c]), wb_dat_i, wb_sel_i));
            end else if (store && cal_gain_i[c]) begin
                next_gn = cal_coef[c];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                data[c]       <= '0;
                coef_off[c]   <= RES_W'(COEF_OFF_RST);
                coef_gn[c]    <= RES_W'(COEF_GN_RST);
                cal_active[c] <= 1'b0;
                lost          <= 1'b0;
            end else begin
                data[c]       <= next_data;
                coef_off[c]   <= next_off;
                coef_gn[c]    <= next_gn;
                cal_active[c] <= next_active;
                lost          <= next_lost;
            end
        end
    end

    assign pri_data_o     = data[0];
    assign aux_data_o     = data[1];
    assign pri_off_coef_o = coef_off[0];
    assign pri_gn_coef_o  = coef_gn[0];
    assign aux_off_coef_o = coef_off[1];
    assign aux_gn_coef_o  = coef_gn[1];

    // Status events
    always_comb begin
        events[ST_DONE0]   = conv_valid_i[0] | cal_done_i[0];
        events[ST_DONE1]   = conv_valid_i[1] | cal_done_i[1];
        events[ST_REFLOSS] = ref_missing & ~ref_missing_d;              // R13
        events[ST_PRIMARY_CAL_ERROR]    = cal_active[0] & ref_missing;               // R15
        events[ST_AUX_CAL_ERROR]    = cal_active[1] & ref_missing;               // R15
        clr = (wr && hit(wb_adr_i, OFS_STATUS)) ? wb_dat_i[ST_W-1:0] & {ST_W{wb_sel_i[0]}}
                                                : '0;
    end

    aic_irq #(
        .N         (ST_W)
    ) u_irq (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .event_i   (events),
        .clr_i     (clr),
        .mask_we_i (wr && hit(wb_adr_i, OFS_MASK) && wb_sel_i[0]),
        .mask_d_i  (wb_dat_i[ST_W-1:0]),
        .status_o  (status),
        .mask_o    (mask),
        .irq_o     (irq_o)
    );
endmodule
`default_nettype wire

// ===== shared/aic_pkg.sv
/*
 * Offsets, fields, reset values and types of the converter control block.
 * Assumes a 32-bit classic Wishbone slave, byte addresses.
 */
`default_nettype none
package aic_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned ADR_W  = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_PRI_CTRL = 8'h00;
    localparam logic [7:0] OFS_AUX_CTRL = 8'h04;
    localparam logic [7:0] OFS_CUR_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_MASK     = 8'h10;
    localparam logic [7:0] OFS_LIVE     = 8'h14;
    localparam logic [7:0] OFS_DATA     [2] = '{8'h18, 8'h1C};
    localparam logic [7:0] OFS_COEF_OFF [2] = '{8'h20, 8'h28};
    localparam logic [7:0] OFS_COEF_GN  [2] = '{8'h24, 8'h2C};

    // Converter control fields
    localparam int unsigned CTL_UNI_BIT   = 0;
    localparam int unsigned CTL_XREF_BIT  = 1;
    localparam int unsigned CTL_RANGE_LSB = 2;
    localparam int unsigned RANGE_W       = 3;
    localparam int unsigned PRI_CTRL_W    = 5;
    localparam int unsigned AUX_CTRL_W    = 2;

    // Current source control fields
    localparam int unsigned CUR_BO_BIT  = 0;
    localparam int unsigned CUR_EXC_LSB = 1;
    localparam int unsigned EXC_W       = 2;
    localparam int unsigned CUR_CTRL_W  = 3;

    // Status / mask bit positions
    localparam int unsigned ST_DONE0   = 0;
    localparam int unsigned ST_DONE1   = 1;
    localparam int unsigned ST_REFLOSS = 2;
    localparam int unsigned ST_PRIMARY_CAL_ERROR    = 3;
    localparam int unsigned ST_AUX_CAL_ERROR    = 4;
    localparam int unsigned ST_W       = 5;

    // Live register bit positions
    localparam int unsigned LV_REFMISS = 0;
    localparam int unsigned LV_CAL0    = 1;
    localparam int unsigned LV_CAL1    = 2;

    // Reset values
    localparam logic [4:0]  PRI_CTRL_RST = 5'h00;
    localparam logic [1:0]  AUX_CTRL_RST = 2'h0;
    localparam logic [2:0]  CUR_CTRL_RST = 3'h0;
    localparam logic [4:0]  MASK_RST     = 5'h00;
    localparam logic [15:0] COEF_OFF_RST = 16'h0000;
    localparam logic [15:0] COEF_GN_RST  = 16'h8000;

    // Excitation routing; outputs count 200 uA units per pin
    typedef enum logic [1:0] {
        EXC_OFF      = 2'h0,
        EXC_SPLIT    = 2'h1,
        EXC_BOTH_ONE = 2'h2,
        EXC_BOTH_TWO = 2'h3
    } aic_exc_t;
endpackage
`default_nettype wire
